// file: shared/cis_pkg.sv
// Overview of operation
// - Add with carry sums accumulator, operand and carry; updates carry and half carry.
// - Subtract with borrow: accumulator minus operand minus inverted carry; updates carry, half carry.
// - mask_test_skip_zero ANDs accumulator with immediate, skips next when zero.
// - Compares run next only on equal, unequal or greater; otherwise skip.
// - Direct byte equals immediate: run next, else skip.
// - Low nibble of first index pointer differs from immediate: run next.
// - decrement_skip_zero decrements register byte, writes back, skips when zero.
// - Register-space operands live at data addresses F0 to FF.
// - Bit set and clear write one selected bit 0 to 7 of a byte.
// - do_next_if_bit runs next only when the selected bit is one.
// - Pointer forms access through an index pointer then step it by one.
// - Program counter is 15 bits: 7-bit high part, 8-bit low part.
// - Table load reads program memory at high part and accumulator into accumulator.
// - Rotates move accumulator one place through carry, in both directions.
// - Carry tests run next only when carry set, or only when clear.
// - Push writes at stack pointer then decrements; pop increments then reads.
// - Vectored dispatch loads high part from vector high, low from vector low.
// - long_jump replaces the whole 15-bit program counter.
// - segment_jump replaces only the low 12 counter bits.
// - subroutine_exit adds 2 to stack pointer, reloads high then low part.
// - irq_exit restores counter like subroutine exit and sets global irq enable.
// - soft_trap_op stacks low then high part, drops stack pointer by 2, jumps 0FF.
// - Skipped instruction takes as many cycles as its byte count.
package cis_pkg;
  localparam int          DATA_W      = 8;
  localparam int          PC_W        = 15;
  localparam int          PCH_W       = 7;
  localparam int          JMP_W       = 12;
  localparam int          NIB_W       = 4;
  localparam int          MEM_DEPTH   = 256;
  localparam logic [7:0]  ADDR_X      = 8'hFC;
  localparam logic [7:0]  ADDR_SP     = 8'hFD;
  localparam logic [7:0]  ADDR_B      = 8'hFE;
  localparam logic [3:0]  REG_SPACE   = 4'hF;
  localparam logic [7:0]  SP_RESET    = 8'h6F;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  STEP_ONE    = 8'h01;
  localparam logic [7:0]  STEP_TWO    = 8'h02;
  localparam logic [14:0] PC_RESET    = 15'h0000;
  localparam logic [14:0] TRAP_TARGET = 15'h00FF;
  localparam logic [1:0]  LEN_ONE     = 2'h1;

  // Operand source selection
  typedef enum logic [1:0] {
    MODE_IMM = 2'b00, MODE_B = 2'b01, MODE_X = 2'b10, MODE_DIR = 2'b11
  } cis_mode_e;

  // Pointer post-update
  typedef enum logic [1:0] {
    UPD_NONE = 2'b00, UPD_INC = 2'b01, UPD_DEC = 2'b10
  } cis_upd_e;

  // Decoded operations presented to the core
  typedef enum logic [5:0] {
    OP_NOP   = 6'b000000, OP_ADD   = 6'b000001, OP_ADC   = 6'b000010, OP_SUBTRACT_WITH_BORROW  = 6'b000011,
    OP_AND   = 6'b000100, OP_OR    = 6'b000101, OP_XOR   = 6'b000110, OP_MASK_TEST_SKIP_ZERO = 6'b000111,
    OP_DO_NEXT_IF_EQUAL  = 6'b001000, OP_DO_NEXT_IF_UNEQUAL  = 6'b001001, OP_DO_NEXT_IF_GREATER  = 6'b001010, OP_IFEQD = 6'b001011,
    OP_DO_NEXT_IF_INDEX_LOW_DIFFERS = 6'b001100, OP_DECREMENT_SKIP_ZERO  = 6'b001101, OP_BIT_SET_OP  = 6'b001110, OP_BIT_CLEAR_OP  = 6'b001111,
    OP_DO_NEXT_IF_BIT = 6'b010000, OP_LDA   = 6'b010001, OP_XA    = 6'b010010, OP_LDMI  = 6'b010011,
    OP_LDBI  = 6'b010100, OP_LDRI  = 6'b010101, OP_LOAD_ACC_FROM_ROM_TABLE  = 6'b010110, OP_RRC   = 6'b010111,
    OP_RLC   = 6'b011000, OP_SC    = 6'b011001, OP_RC    = 6'b011010, OP_IFC   = 6'b011011,
    OP_DO_NEXT_IF_NO_CARRY  = 6'b011100, OP_PUSH  = 6'b011101, OP_POP   = 6'b011110, OP_VIS   = 6'b011111,
    OP_LONG_JUMP  = 6'b100000, OP_JMP   = 6'b100001, OP_RET   = 6'b100010, OP_IRQ_EXIT  = 6'b100011,
    OP_SOFT_TRAP_OP  = 6'b100100
  } cis_op_e;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_EXEC = 3'b000, ST_SKIP = 3'b001, ST_LOAD_ACC_FROM_ROM_TABLE = 3'b010, ST_VIS_HI = 3'b011, ST_VIS_LO = 3'b100
  } cis_state_e;
endpackage

// file: logic/cis_core.sv
`timescale 1ns/1ps
module cis_core (
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  // Decoded instruction
  input  wire logic                     instr_valid_i,
  output logic                          instr_ready_o,
  input  wire cis_pkg::cis_op_e         op_i,
  input  wire cis_pkg::cis_mode_e       mode_i,
  input  wire cis_pkg::cis_upd_e        upd_i,
  input  wire logic [1:0]               len_i,
  input  wire logic [7:0]               imm_i,
  input  wire logic [7:0]               dir_i,
  input  wire logic [2:0]               bit_i,
  input  wire logic [14:0]              addr_i,
  input  wire logic [14:0]              vec_addr_i,
  // Program memory read port
  output logic [14:0]                   rom_addr_o,
  input  wire logic [7:0]               rom_data_i,
  // Architectural state
  output logic [7:0]                    acc_o,
  output logic [7:0]                    b_o,
  output logic [7:0]                    x_o,
  output logic [7:0]                    sp_o,
  output logic [14:0]                   pc_o,
  output logic                          carry_o,
  output logic                          half_carry_o,
  output logic                          gie_o,
  output logic                          skip_o
);
  import cis_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State and next values
  logic [7:0]  mem_q [MEM_DEPTH];
  logic [7:0]  acc_q, acc_d, b_q, b_d, x_q, x_d, sp_q, sp_d;
  logic [14:0] pc_q, pc_d, rom_addr_q, rom_addr_d, pc_inc;
  logic        c_q, c_d, hc_q, hc_d, gie_q, gie_d, skip_q, skip_d;
  logic [1:0]  cnt_q, cnt_d;
  cis_state_e  state_q, state_d;
  logic        go, exec, skipping;
  logic [7:0]  ea, reg_a, opnd, byte_v, sp_up1, sp_up2, ret_hi;
  logic [8:0]  adc_sum, sub_sum;
  logic [4:0]  adc_nib, sub_nib;
  logic        wr0_en, wr1_en;
  logic [7:0]  wr0_a, wr0_d, wr1_a, wr1_d;

  // Data read; pointer bytes come from their own registers
  function automatic logic [7:0] rd(input logic [7:0] a);
    case (a)
      ADDR_B:  rd = b_q;
      ADDR_X:  rd = x_q;
      ADDR_SP: rd = sp_q;
      default: rd = mem_q[a];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operand datapath
  assign go       = instr_valid_i & instr_ready_o;
  assign exec     = go & ~skip_q;
  assign skipping = go & skip_q;
  assign pc_inc   = pc_q + {13'h0000, (len_i == 2'h0) ? LEN_ONE : len_i};
  assign ea       = (mode_i == MODE_B) ? b_q : (mode_i == MODE_X) ? x_q : dir_i;
  assign reg_a    = {REG_SPACE, dir_i[NIB_W-1:0]};
  assign opnd     = (mode_i == MODE_IMM) ? imm_i : rd(ea);
  assign sp_up1   = sp_q + STEP_ONE;
  assign sp_up2   = sp_q + STEP_TWO;
  // Stacked high part; a function result cannot be sliced directly
  assign ret_hi   = rd(sp_up1);
  // Carry out of bit 7 and bit 3; subtract carry means no borrow
  assign adc_sum  = {1'b0, acc_q} + {1'b0, opnd} + {8'h00, c_q};
  assign adc_nib  = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]} + {4'h0, c_q};
  assign sub_sum  = {1'b0, acc_q} + {1'b0, ~opnd} + {8'h00, c_q};
  assign sub_nib  = {1'b0, acc_q[3:0]} + {1'b0, ~opnd[3:0]} + {4'h0, c_q};
  assign instr_ready_o = (state_q == ST_EXEC);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state decode
  always_comb begin
    acc_d = acc_q;
    c_d = c_q;
    hc_d = hc_q;
    gie_d = gie_q;
    b_d = b_q;
    x_d = x_q;
    sp_d = sp_q;
    pc_d = pc_q;
    skip_d = skip_q;
    cnt_d = cnt_q;
    state_d = state_q;
    rom_addr_d = rom_addr_q;
    wr0_en = 1'b0;
    wr0_a = BYTE_ZERO;
    wr0_d = BYTE_ZERO;
    wr1_en = 1'b0;
    wr1_a = BYTE_ZERO;
    wr1_d = BYTE_ZERO;
    byte_v = rd(ea);
    case (state_q)
      ST_EXEC: begin
        if (skipping) begin
          // Skipped: only the counter moves, one cycle per byte
          pc_d = pc_inc;
          skip_d = 1'b0;
          if (len_i > LEN_ONE) begin
            cnt_d = len_i - LEN_ONE;
            state_d = ST_SKIP;
          end
        end else if (exec) begin
          pc_d = pc_inc;
          case (op_i)
            OP_ADD: acc_d = adc_sum[7:0] - {7'h00, c_q};
            OP_ADC: begin
              acc_d = adc_sum[7:0];
              c_d = adc_sum[8];
              hc_d = adc_nib[4];
            end
            OP_SUBTRACT_WITH_BORROW: begin
              acc_d = sub_sum[7:0];
              c_d = sub_sum[8];
              hc_d = sub_nib[4];
            end
            OP_AND:   acc_d = acc_q & opnd;
            OP_OR:    acc_d = acc_q | opnd;
            OP_XOR:   acc_d = acc_q ^ opnd;
            OP_MASK_TEST_SKIP_ZERO: skip_d = ((acc_q & imm_i) == BYTE_ZERO);
            OP_DO_NEXT_IF_EQUAL:  skip_d = (acc_q != opnd);
            OP_DO_NEXT_IF_UNEQUAL:  skip_d = (acc_q == opnd);
            OP_DO_NEXT_IF_GREATER:  skip_d = !(acc_q > opnd);
            OP_IFEQD: skip_d = (rd(dir_i) != imm_i);
            OP_DO_NEXT_IF_INDEX_LOW_DIFFERS: skip_d = (b_q[NIB_W-1:0] == imm_i[NIB_W-1:0]);
            OP_DECREMENT_SKIP_ZERO: begin
              wr0_en = 1'b1;
              wr0_a = reg_a;
              wr0_d = rd(reg_a) - STEP_ONE;
              skip_d = (wr0_d == BYTE_ZERO);
            end
            OP_BIT_SET_OP, OP_BIT_CLEAR_OP: begin
              byte_v[bit_i] = (op_i == OP_BIT_SET_OP);
              wr0_en = 1'b1;
              wr0_a = ea;
              wr0_d = byte_v;
            end
            OP_DO_NEXT_IF_BIT: skip_d = (mode_i == MODE_IMM) ? !acc_q[bit_i] : !byte_v[bit_i];
            OP_LDA: acc_d = opnd;
            OP_XA: begin
              acc_d = rd(ea);
              wr0_en = 1'b1;
              wr0_a = ea;
              wr0_d = acc_q;
            end
            OP_LDMI: begin
              wr0_en = 1'b1;
              wr0_a = ea;
              wr0_d = imm_i;
            end
            OP_LDBI: b_d = imm_i;
            OP_LDRI: begin
              wr0_en = 1'b1;
              wr0_a = reg_a;
              wr0_d = imm_i;
            end
            OP_LOAD_ACC_FROM_ROM_TABLE: begin
              rom_addr_d = {pc_inc[PC_W-1:DATA_W], acc_q};
              state_d = ST_LOAD_ACC_FROM_ROM_TABLE;
            end
            OP_RRC: begin
              acc_d = {c_q, acc_q[7:1]};
              c_d = acc_q[0];
            end
            OP_RLC: begin
              acc_d = {acc_q[6:0], c_q};
              c_d = acc_q[7];
            end
            OP_SC: begin
              c_d = 1'b1;
              hc_d = 1'b1;
            end
            OP_RC: begin
              c_d = 1'b0;
              hc_d = 1'b0;
            end
            OP_IFC:  skip_d = !c_q;
            OP_DO_NEXT_IF_NO_CARRY: skip_d = c_q;
            OP_PUSH: begin
              wr0_en = 1'b1;
              wr0_a = sp_q;
              wr0_d = acc_q;
              sp_d = sp_q - STEP_ONE;
            end
            OP_POP: begin
              sp_d = sp_up1;
              acc_d = rd(sp_up1);
            end
            OP_VIS: begin
              rom_addr_d = vec_addr_i;
              state_d = ST_VIS_HI;
            end
            OP_LONG_JUMP: pc_d = addr_i;
            OP_JMP:  pc_d = {pc_inc[PC_W-1:JMP_W], addr_i[JMP_W-1:0]};
            OP_RET, OP_IRQ_EXIT: begin
              sp_d = sp_up2;
              pc_d = {ret_hi[PCH_W-1:0], rd(sp_up2)};
              if (op_i == OP_IRQ_EXIT) begin
                gie_d = 1'b1;
              end
            end
            OP_SOFT_TRAP_OP: begin
              wr0_en = 1'b1;
              wr0_a = sp_q;
              wr0_d = pc_inc[DATA_W-1:0];
              wr1_en = 1'b1;
              wr1_a = sp_q - STEP_ONE;
              wr1_d = {1'b0, pc_inc[PC_W-1:DATA_W]};
              sp_d = sp_q - STEP_TWO;
              pc_d = TRAP_TARGET;
            end
            default: ;
          endcase
          // Post-update of the pointer used by the access
          if ((op_i == OP_LDA || op_i == OP_XA || op_i == OP_LDMI) && upd_i != UPD_NONE) begin
            if (mode_i == MODE_B) begin
              b_d = (upd_i == UPD_INC) ? b_q + STEP_ONE : b_q - STEP_ONE;
            end else if (mode_i == MODE_X) begin
              x_d = (upd_i == UPD_INC) ? x_q + STEP_ONE : x_q - STEP_ONE;
            end
          end
        end
      end
      ST_SKIP: begin
        cnt_d = cnt_q - LEN_ONE;
        if (cnt_q == LEN_ONE) begin
          state_d = ST_EXEC;
        end
      end
      ST_LOAD_ACC_FROM_ROM_TABLE: begin
        acc_d = rom_data_i;
        state_d = ST_EXEC;
      end
      ST_VIS_HI: begin
        pc_d = {rom_data_i[PCH_W-1:0], pc_q[DATA_W-1:0]};
        rom_addr_d = rom_addr_q + 15'h0001;
        state_d = ST_VIS_LO;
      end
      ST_VIS_LO: begin
        pc_d = {pc_q[PC_W-1:DATA_W], rom_data_i};
        state_d = ST_EXEC;
      end
      default: state_d = ST_EXEC;
    endcase
    // Port 0 writes landing on pointer addresses go to the pointer registers
    if (wr0_en && wr0_a == ADDR_B) b_d = wr0_d;
    if (wr0_en && wr0_a == ADDR_X) x_d = wr0_d;
    if (wr0_en && wr0_a == ADDR_SP) sp_d = wr0_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= ST_EXEC;
      cnt_q <= 2'h0;
      skip_q <= 1'b0;
      rom_addr_q <= PC_RESET;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      skip_q <= skip_d;
      rom_addr_q <= rom_addr_d;
    end
  end

  // Program counter, kept whole; high and low parts are slices
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_q <= PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Accumulator and status flags
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_q <= BYTE_ZERO;
      c_q <= 1'b0;
      hc_q <= 1'b0;
      gie_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      c_q <= c_d;
      hc_q <= hc_d;
      gie_q <= gie_d;
    end
  end

  // Pointer registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      b_q <= BYTE_ZERO;
      x_q <= BYTE_ZERO;
      sp_q <= SP_RESET;
    end else begin
      b_q <= b_d;
      x_q <= x_d;
      sp_q <= sp_d;
    end
  end

  // Data memory; port 0 wins when both ports hit one byte
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_q[i] <= BYTE_ZERO;
      end
    end else begin
      if (wr1_en) mem_q[wr1_a] <= wr1_d;
      if (wr0_en) mem_q[wr0_a] <= wr0_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rom_addr_o   = rom_addr_q;
  assign acc_o        = acc_q;
  assign b_o          = b_q;
  assign x_o          = x_q;
  assign sp_o         = sp_q;
  assign pc_o         = pc_q;
  assign carry_o      = c_q;
  assign half_carry_o = hc_q;
  assign gie_o        = gie_q;
  assign skip_o       = skip_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_ADC_RESULT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    exec && op_i == OP_ADC |=> acc_q == $past(adc_sum[7:0]) && c_q == $past(adc_sum[8]))
    else $error("add with carry result wrong");
  AST_SUBTRACT_WITH_BORROW_FLAGS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    exec && op_i == OP_SUBTRACT_WITH_BORROW |=> c_q == $past(sub_sum[8]) && hc_q == $past(sub_nib[4]))
    else $error("subtract flags wrong");
  AST_MASK_TEST_SKIP_ZERO_SKIP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    exec && op_i == OP_MASK_TEST_SKIP_ZERO |=> skip_q == ($past(acc_q & imm_i) == BYTE_ZERO) && acc_q == $past(acc_q))
    else $error("mask test skip wrong");
  AST_DO_NEXT_IF_INDEX_LOW_DIFFERS_SKIP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    exec && op_i == OP_DO_NEXT_IF_INDEX_LOW_DIFFERS |=> skip_q == ($past(b_q[3:0]) == $past(imm_i[3:0])))
    else $error("index nibble test wrong");
  AST_PUSH_SP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    exec && op_i == OP_PUSH |=> sp_q == $past(sp_q) - STEP_ONE)
    else $error("push did not drop stack pointer");
  AST_JMP_UPPER: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    exec && op_i == OP_JMP |=> pc_q[14:12] == $past(pc_inc[14:12]) && pc_q[11:0] == $past(addr_i[11:0]))
    else $error("segment jump target wrong");
  AST_IRQ_EXIT_GIE: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    exec && op_i == OP_IRQ_EXIT |=> gie_q && sp_q == $past(sp_q) + STEP_TWO)
    else $error("irq exit state wrong");
  AST_SOFT_TRAP_OP_PC: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    exec && op_i == OP_SOFT_TRAP_OP |=> pc_q == TRAP_TARGET && sp_q == $past(sp_q) - STEP_TWO)
    else $error("soft trap state wrong");
  AST_SKIP_HOLDS: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    skipping |=> acc_q == $past(acc_q) && sp_q == $past(sp_q) && !skip_q && pc_q == $past(pc_inc))
    else $error("skipped instruction changed state");
  AST_SKIP_CYCLES: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    skipping && len_i == 2'h3 |=> !instr_ready_o [*2] ##1 instr_ready_o)
    else $error("skip cycle count wrong");
  AST_LOAD_ACC_FROM_ROM_TABLE_LOAD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    exec && op_i == OP_LOAD_ACC_FROM_ROM_TABLE |=> state_q == ST_LOAD_ACC_FROM_ROM_TABLE ##2 acc_q == $past(rom_data_i))
    else $error("table load wrong");
endmodule

// file: dv/tb_cpu_instruction_semantics.sv
`timescale 1ns/1ps
module tb_cpu_instruction_semantics;
  import cis_pkg::*;

  // Stimulus, driven 2 ns after the rising edge except the clock; rom_data_i follows rom_addr_o
  logic        clk_i         = 1'b0;
  logic        reset_n_i     = 1'b0;
  logic        instr_valid_i = 1'b0;
  cis_op_e     op_i          = OP_NOP;
  cis_mode_e   mode_i        = MODE_IMM;
  cis_upd_e    upd_i         = UPD_NONE;
  logic [1:0]  len_i         = 2'h1;
  logic [7:0]  imm_i         = 8'h00;
  logic [7:0]  dir_i         = 8'h00;
  logic [2:0]  bit_i         = 3'h0;
  logic [14:0] addr_i        = 15'h0000;
  logic [14:0] vec_addr_i    = 15'h0000;
  logic [7:0]  rom_data_i;
  // Observed outputs
  logic        instr_ready_o;
  logic        carry_o;
  logic        half_carry_o;
  logic        gie_o;
  logic        skip_o;
  logic [7:0]  acc_o;
  logic [7:0]  b_o;
  logic [7:0]  x_o;
  logic [7:0]  sp_o;
  logic [14:0] pc_o;
  logic [14:0] rom_addr_o;
  logic [14:0] pc_t;
  int          fails         = 0;
  int          checks_done   = 0;
  // Compare table: all keep acc at 40 so each compare outcome follows from the operand, each carry test from carry
  cis_op_e     t_op[8]  = '{OP_DO_NEXT_IF_EQUAL, OP_DO_NEXT_IF_EQUAL, OP_DO_NEXT_IF_UNEQUAL, OP_DO_NEXT_IF_GREATER, OP_DO_NEXT_IF_GREATER, OP_RC, OP_IFC, OP_DO_NEXT_IF_NO_CARRY};
  logic [7:0]  t_imm[8] = '{8'h40, 8'h41, 8'h40, 8'h3F, 8'h40, 8'h00, 8'h00, 8'h00};
  logic        t_exp[8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  // Program memory: address-dependent pattern so a wrong address shows up
  function automatic logic [7:0] rom_f(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]} ^ 8'hA5;
  endfunction
  assign rom_data_i = rom_f(rom_addr_o);

  always #12.5 clk_i = ~clk_i;

  cis_core cis_core_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o),
    .op_i(op_i), .mode_i(mode_i), .upd_i(upd_i), .len_i(len_i), .imm_i(imm_i), .dir_i(dir_i),
    .bit_i(bit_i), .addr_i(addr_i), .vec_addr_i(vec_addr_i), .rom_addr_o(rom_addr_o),
    .rom_data_i(rom_data_i), .acc_o(acc_o), .b_o(b_o), .x_o(x_o), .sp_o(sp_o), .pc_o(pc_o),
    .carry_o(carry_o), .half_carry_o(half_carry_o), .gie_o(gie_o), .skip_o(skip_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Bounded wait so a stuck sequencer cannot hang the run
  task automatic wait_ready();
    int n;
    n = 0;
    while (instr_ready_o !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #2;
      n++;
    end
    chk("ready", {15'h0, instr_ready_o}, 16'h1);
  endtask

  task automatic go(input cis_op_e op, input logic [7:0] imm = 8'h00, input cis_mode_e m = MODE_IMM,
                    input logic [7:0] dir = 8'h00, input logic [2:0] bn = 3'h0,
                    input cis_upd_e u = UPD_NONE, input logic [1:0] l = 2'h1);
    // Idle edge so valid is never lowered and raised in one time step
    @(posedge clk_i);
    #2;
    wait_ready();
    op_i = op;
    imm_i = imm;
    mode_i = m;
    dir_i = dir;
    bit_i = bn;
    upd_i = u;
    len_i = l;
    instr_valid_i = 1'b1;
    @(posedge clk_i);
    #2;
    instr_valid_i = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_arith();
    go(OP_LDA, 8'h3A);
    go(OP_SC);
    pc_t = pc_o;
    go(OP_ADC, 8'h0F, MODE_IMM, 8'h00, 3'h0, UPD_NONE, 2'h2);
    chk("adc_acc", acc_o, 16'h4A);
    chk("adc_c", carry_o, 16'h0);
    chk("adc_hc", half_carry_o, 16'h1);
    chk("adc_pc", pc_o, pc_t + 15'h2);
    go(OP_SC);
    go(OP_SUBTRACT_WITH_BORROW, 8'h0A);
    chk("subtract_with_borrow_acc", acc_o, 16'h40);
    chk("subtract_with_borrow_c", carry_o, 16'h1);
    chk("subtract_with_borrow_hc", half_carry_o, 16'h1);
    go(OP_LDA, 8'h81);
    go(OP_SC);
    go(OP_RLC);
    chk("rlc", {carry_o, acc_o}, 16'h103);
    go(OP_RC);
    go(OP_RRC);
    chk("rrc", {carry_o, acc_o}, 16'h101);
  endtask

  // Three-byte victim: ready must drop for two cycles, state must not move
  task automatic t_skip();
    go(OP_LDA, 8'h40);
    go(OP_MASK_TEST_SKIP_ZERO, 8'h40);
    chk("mask_test_skip_zero_nz", skip_o, 16'h0);
    go(OP_MASK_TEST_SKIP_ZERO, 8'h0F);
    chk("mask_test_skip_zero_z", skip_o, 16'h1);
    pc_t = pc_o;
    go(OP_LDA, 8'h77, MODE_IMM, 8'h00, 3'h0, UPD_NONE, 2'h3);
    chk("skip_rdy1", instr_ready_o, 16'h0);
    @(posedge clk_i);
    #2;
    chk("skip_rdy2", instr_ready_o, 16'h0);
    @(posedge clk_i);
    #2;
    chk("skip_rdy3", instr_ready_o, 16'h1);
    chk("skip_pc", pc_o, pc_t + 15'h3);
    chk("skip_acc", acc_o, 16'h40);
    for (int i = 0; i < 8; i++) begin
      go(t_op[i], t_imm[i]);
      chk("cmp_skip", skip_o, {15'h0, t_exp[i]});
      go(OP_NOP);
    end
  endtask

  task automatic t_stack();
    go(OP_PUSH);
    chk("push_sp", sp_o, 16'h6E);
    go(OP_LDA, 8'h00);
    go(OP_POP);
    chk("pop", {sp_o, acc_o}, 16'h6F40);
    pc_t = pc_o;
    go(OP_SOFT_TRAP_OP);
    chk("trap", {sp_o, 1'b0, pc_o[14:8]}, 16'h6D00);
    chk("trap_pc", pc_o, 16'h00FF);
    go(OP_RET);
    chk("ret_pc", pc_o, pc_t + 15'h1);
    chk("ret_sp", sp_o, 16'h6F);
    go(OP_SOFT_TRAP_OP);
    go(OP_IRQ_EXIT);
    chk("irq_exit", {gie_o, pc_o}, {1'b1, pc_t + 15'h2});
  endtask

  task automatic t_flow();
    addr_i = 15'h5ABC;
    go(OP_LONG_JUMP);
    chk("long_jump", pc_o, 16'h5ABC);
    addr_i = 15'h0123;
    go(OP_JMP, 8'h00, MODE_IMM, 8'h00, 3'h0, UPD_NONE, 2'h2);
    chk("jmp", pc_o, 16'h5123);
    go(OP_LDA, 8'h33);
    pc_t = pc_o + 15'h1;
    go(OP_LOAD_ACC_FROM_ROM_TABLE);
    wait_ready();
    chk("load_acc_from_rom_table", acc_o, rom_f({pc_t[14:8], 8'h33}));
    vec_addr_i = 15'h0120;
    go(OP_VIS);
    wait_ready();
    chk("vis", pc_o, {rom_f(15'h0120), rom_f(15'h0121)} & 16'h7FFF);
  endtask

  // Register space and memory operands; reset leaves memory at zero
  task automatic t_mem();
    go(OP_LDBI, 8'h10);
    go(OP_LDMI, 8'h5C, MODE_B, 8'h00, 3'h0, UPD_INC);
    chk("ldmi_b", b_o, 16'h11);
    go(OP_LDA, 8'h77, MODE_B, 8'h00, 3'h0, UPD_DEC);
    chk("lda_dec", {b_o, acc_o}, 16'h1000);
    go(OP_IFEQD, 8'h5C, MODE_DIR, 8'h10);
    chk("ifeqd_eq", skip_o, 16'h0);
    go(OP_IFEQD, 8'h5D, MODE_DIR, 8'h10);
    chk("ifeqd_ne", skip_o, 16'h1);
    go(OP_NOP);
    go(OP_DO_NEXT_IF_INDEX_LOW_DIFFERS, 8'h00);
    chk("do_next_if_index_low_differs_eq", skip_o, 16'h1);
    go(OP_NOP);
    go(OP_DO_NEXT_IF_INDEX_LOW_DIFFERS, 8'h01);
    chk("do_next_if_index_low_differs_ne", skip_o, 16'h0);
    go(OP_LDRI, 8'h01, MODE_IMM, 8'hF3);
    go(OP_DECREMENT_SKIP_ZERO, 8'h00, MODE_IMM, 8'hF3);
    chk("decrement_skip_zero_z", skip_o, 16'h1);
    go(OP_NOP);
    go(OP_DECREMENT_SKIP_ZERO, 8'h00, MODE_IMM, 8'hF3);
    chk("decrement_skip_zero_nz", skip_o, 16'h0);
    go(OP_LDA, 8'h00, MODE_DIR, 8'hF3);
    chk("decrement_skip_zero_val", acc_o, 16'hFF);
    go(OP_BIT_SET_OP, 8'h00, MODE_DIR, 8'h20, 3'h5);
    go(OP_DO_NEXT_IF_BIT, 8'h00, MODE_DIR, 8'h20, 3'h5);
    chk("do_next_if_bit_1", skip_o, 16'h0);
    go(OP_LDA, 8'h00, MODE_DIR, 8'h20);
    chk("bit_set_op", acc_o, 16'h20);
    go(OP_BIT_CLEAR_OP, 8'h00, MODE_DIR, 8'h20, 3'h5);
    go(OP_DO_NEXT_IF_BIT, 8'h00, MODE_DIR, 8'h20, 3'h5);
    chk("do_next_if_bit_0", skip_o, 16'h1);
    go(OP_NOP);
    go(OP_LDA, 8'h00, MODE_DIR, 8'h20);
    chk("bit_clear_op", acc_o, 16'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and main sequence
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    #2;
    reset_n_i = 1'b1;
    chk("rst", {sp_o, acc_o}, 16'h6F00);
    t_arith();
    t_skip();
    t_stack();
    t_flow();
    t_mem();
    give_verdict();
  end

  // Whole run is under two hundred cycles; this 4000-cycle limit cuts a hang short
  initial begin
    #(25 * 4000);
    fails++;
    give_verdict();
  end
endmodule
